// ==== pkg/rsp_pkg.sv ====
// rsp_pkg: register map, field positions, reset values and sizes for the
// reset-synchronized three-phase pwm generator.
// assumes a plain register port with 16-bit data and one system clock.
package rsp_pkg;
   localparam int unsigned RSP_DW = 16;
   localparam int unsigned RSP_AW = 5;
   // register offsets (word index on the register port)
   localparam logic [4:0] RSP_OFF_MCNT  = 5'h00;
   localparam logic [4:0] RSP_OFF_SCNT  = 5'h01;
   localparam logic [4:0] RSP_OFF_PER   = 5'h02;
   localparam logic [4:0] RSP_OFF_D1    = 5'h03;
   localparam logic [4:0] RSP_OFF_D2    = 5'h04;
   localparam logic [4:0] RSP_OFF_D3    = 5'h05;
   localparam logic [4:0] RSP_OFF_PERB  = 5'h06;
   localparam logic [4:0] RSP_OFF_D1B   = 5'h07;
   localparam logic [4:0] RSP_OFF_D2B   = 5'h08;
   localparam logic [4:0] RSP_OFF_D3B   = 5'h09;
   localparam logic [4:0] RSP_OFF_MODE  = 5'h0A;
   localparam logic [4:0] RSP_OFF_OCTL  = 5'h0B;
   localparam logic [4:0] RSP_OFF_RUN   = 5'h0C;
   localparam logic [4:0] RSP_OFF_ISTAT = 5'h0D;
   localparam logic [4:0] RSP_OFF_IEN   = 5'h0E;
   localparam logic [4:0] RSP_OFF_ICLR  = 5'h0F;
   localparam logic [4:0] RSP_OFF_PRE   = 5'h10;
   // master_mode_reg fields
   localparam int unsigned RSP_BIT_BFA   = 0;
   localparam int unsigned RSP_BIT_BFB   = 1;
   // output_control_reg fields
   localparam int unsigned RSP_BIT_POS_LEVEL_SELECT  = 0;
   localparam int unsigned RSP_BIT_NEG_LEVEL_SELECT  = 1;
   localparam int unsigned RSP_BIT_TGLEN = 2;
   localparam int unsigned RSP_BIT_GPIO  = 3;
   // interrupt status fields
   localparam int unsigned RSP_BIT_IPER  = 0;
   localparam int unsigned RSP_BIT_ID1   = 1;
   localparam int unsigned RSP_BIT_ID2   = 2;
   localparam int unsigned RSP_BIT_ID3   = 3;
   localparam int unsigned RSP_NIRQ      = 4;
   // reset values
   localparam logic [15:0] RSP_RST_CNT  = 16'h0000;
   localparam logic [15:0] RSP_RST_PER  = 16'hFFFF;
   localparam logic [15:0] RSP_RST_DUTY = 16'hFFFF;
   localparam logic [1:0]  RSP_RST_MODE = 2'h0;
   localparam logic [3:0]  RSP_RST_OCTL = 4'h3;
   localparam logic [7:0]  RSP_RST_PRE  = 8'h00;
   localparam logic [15:0] RSP_RD_ZERO  = 16'h0000;
endpackage : rsp_pkg

// ==== core/rsp_prescale.sv ====
// rsp_prescale: counter-clock enable divider.
// assumes one system clock; emits a one-cycle tick every (div+1) clocks.
`timescale 1ns/1ps
module rsp_prescale
   import rsp_pkg::*;
#(
   parameter int unsigned W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         run,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   logic [W-1:0] cnt_q;

   initial begin
      if (W < 1 || W > 16) $error("prescaler width out of range");
   end

   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (cnt_q >= div) begin
         cnt_q <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'b0;
      end
   end
endmodule : rsp_prescale

// ==== core/rsp_pwm3.sv ====
// rsp_pwm3: reset-synchronized three-phase pwm generator, registers and pins.
// assumes a synchronous register port, read data one cycle after read strobe.
//
// Overview of operation
// - two linked channels form one generator, three phases, shared change points
// - master counter counts up, clears to zero on period match
// - each output toggles on its duty match and on counter clear
// - three positive pins and three antiphase pins, six lines
// - duty one drives pair 1, duty two pair 2, duty three pair 3
// - cycle toggle pin follows period; otherwise usable as general output
// - both counters start at zero
// - buffers exist for period and all three duty registers
// - both level select bits one gives high-active outputs
// - counters and general registers are sixteen bits
// - on period match buffers copy into compare registers
// - period match raises compare interrupt every carrier period
// - duty zero gives one-count pulse; duty at or above period one toggle
// - both buffer enable bits set turn buffering on
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module rsp_pwm3
   import rsp_pkg::*;
#(
   parameter int unsigned DW = RSP_DW,
   parameter int unsigned PW = 8
) (
   input  wire logic              CLK_SYS,
   input  wire logic              SYS_RST,
   input  wire logic [RSP_AW-1:0] ADDR,
   input  wire logic [DW-1:0]     WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic      [DW-1:0]     RDATA,
   output logic                   IRQ,
   output logic                   CYCLE_TOGGLE_PIN,
   output logic                   PHASE_ONE_POS_PIN,
   output logic                   PHASE_ONE_NEG_PIN,
   output logic                   PHASE_TWO_POS_PIN,
   output logic                   PHASE_TWO_NEG_PIN,
   output logic                   PHASE_THREE_POS_PIN,
   output logic                   PHASE_THREE_NEG_PIN
);
   logic [DW-1:0]       master_counter_q;
   logic [DW-1:0]       slave_counter_q;
   logic [DW-1:0]       period_compare_q;
   logic [DW-1:0]       duty_q [3];
   logic [DW-1:0]       period_buffer_q;
   logic [DW-1:0]       dbuf_q [3];
   logic [1:0]          master_mode_q;
   logic [3:0]          output_control_q;
   logic                run_q;
   logic [PW-1:0]       pre_q;
   logic [RSP_NIRQ-1:0] istat_q;
   logic [RSP_NIRQ-1:0] ien_q;
   logic [2:0]          phase_q;
   logic                toggle_q;
   logic                tick;
   logic                per_hit;
   logic [2:0]          duty_hit;
   logic                buf_on;
   logic [RSP_NIRQ-1:0] ev;

   initial begin
      if (DW != 16) $error("counter width must be 16");
   end

   function automatic logic wr_at(input logic [RSP_AW-1:0] off);
      return WR && (ADDR == off);
   endfunction : wr_at

   rsp_prescale #(.W(PW)) u_pre (
      .clk  (CLK_SYS),
      .rst  (SYS_RST),
      .run  (run_q),
      .div  (pre_q),
      .tick (tick)
   );

   assign buf_on  = master_mode_q[RSP_BIT_BFA] & master_mode_q[RSP_BIT_BFB];
   assign per_hit = tick && (master_counter_q == period_compare_q);

   // duty at or above period never matches before clear
   generate
      for (genvar i = 0; i < 3; i++) begin : g_hit
         assign duty_hit[i] = tick && (master_counter_q == duty_q[i]) && (duty_q[i] < period_compare_q);
      end
   endgenerate

   assign ev = {duty_hit, per_hit};

   // up-count, clear on period match; zero start
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         master_counter_q <= RSP_RST_CNT;
      end else if (wr_at(RSP_OFF_MCNT)) begin
         master_counter_q <= WDATA;
      end else if (per_hit) begin
         master_counter_q <= RSP_RST_CNT;
      end else if (tick) begin
         master_counter_q <= master_counter_q + 1'b1;
      end
   end

   // slave channel runs in lockstep with master
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         slave_counter_q <= RSP_RST_CNT;
      end else if (wr_at(RSP_OFF_SCNT)) begin
         slave_counter_q <= WDATA;
      end else if (per_hit) begin
         slave_counter_q <= RSP_RST_CNT;
      end else if (tick) begin
         slave_counter_q <= slave_counter_q + 1'b1;
      end
   end

   // buffer transfer at period match; buffers written by software
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         period_compare_q <= RSP_RST_PER;
      end else if (per_hit && buf_on) begin
         period_compare_q <= period_buffer_q;
      end else if (wr_at(RSP_OFF_PER)) begin
         period_compare_q <= WDATA;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         period_buffer_q <= RSP_RST_PER;
      end else if (wr_at(RSP_OFF_PERB)) begin
         period_buffer_q <= WDATA;
      end
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_duty
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST) begin
               duty_q[i] <= RSP_RST_DUTY;
            end else if (per_hit && buf_on) begin
               duty_q[i] <= dbuf_q[i];
            end else if (wr_at(RSP_OFF_D1 + 5'(i))) begin
               duty_q[i] <= WDATA;
            end
         end
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST) begin
               dbuf_q[i] <= RSP_RST_DUTY;
            end else if (wr_at(RSP_OFF_D1B + 5'(i))) begin
               dbuf_q[i] <= WDATA;
            end
         end
         // toggle on duty match and on clear
         always_ff @(posedge CLK_SYS) begin
            if (SYS_RST || !run_q) begin
               phase_q[i] <= 1'b0;
            end else if (per_hit || duty_hit[i]) begin
               phase_q[i] <= ~phase_q[i];
            end
         end
      end
   endgenerate

   // control registers
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         master_mode_q    <= RSP_RST_MODE;
         output_control_q <= RSP_RST_OCTL;
         run_q            <= 1'b0;
         pre_q            <= PW'(RSP_RST_PRE);
         ien_q            <= '0;
      end else begin
         if (wr_at(RSP_OFF_MODE)) master_mode_q <= WDATA[1:0];
         if (wr_at(RSP_OFF_OCTL)) output_control_q <= WDATA[3:0];
         if (wr_at(RSP_OFF_RUN)) run_q <= WDATA[0];
         if (wr_at(RSP_OFF_PRE)) pre_q <= WDATA[PW-1:0];
         if (wr_at(RSP_OFF_IEN)) ien_q <= WDATA[RSP_NIRQ-1:0];
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         istat_q <= '0;
      end else begin
         istat_q <= (istat_q & ~(wr_at(RSP_OFF_ICLR) ? WDATA[RSP_NIRQ-1:0] : '0)) | ev;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |((istat_q | ev) & ien_q);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !run_q) begin
         toggle_q <= 1'b0;
      end else if (per_hit) begin
         toggle_q <= ~toggle_q;
      end
   end

   // six output lines; level select; complement, no dead time
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         PHASE_ONE_POS_PIN   <= 1'b0;
         PHASE_ONE_NEG_PIN   <= 1'b0;
         PHASE_TWO_POS_PIN   <= 1'b0;
         PHASE_TWO_NEG_PIN   <= 1'b0;
         PHASE_THREE_POS_PIN <= 1'b0;
         PHASE_THREE_NEG_PIN <= 1'b0;
         CYCLE_TOGGLE_PIN    <= 1'b0;
      end else begin
         PHASE_ONE_POS_PIN   <= phase_q[0] ^ ~output_control_q[RSP_BIT_POS_LEVEL_SELECT];
         PHASE_ONE_NEG_PIN   <= ~phase_q[0] ^ ~output_control_q[RSP_BIT_NEG_LEVEL_SELECT];
         PHASE_TWO_POS_PIN   <= phase_q[1] ^ ~output_control_q[RSP_BIT_POS_LEVEL_SELECT];
         PHASE_TWO_NEG_PIN   <= ~phase_q[1] ^ ~output_control_q[RSP_BIT_NEG_LEVEL_SELECT];
         PHASE_THREE_POS_PIN <= phase_q[2] ^ ~output_control_q[RSP_BIT_POS_LEVEL_SELECT];
         PHASE_THREE_NEG_PIN <= ~phase_q[2] ^ ~output_control_q[RSP_BIT_NEG_LEVEL_SELECT];
         CYCLE_TOGGLE_PIN    <= output_control_q[RSP_BIT_TGLEN] ? toggle_q : output_control_q[RSP_BIT_GPIO];
      end
   end

   // read port, unmapped reads zero
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         RDATA <= RSP_RD_ZERO;
      end else if (RD) begin
         case (ADDR)
            RSP_OFF_MCNT:  RDATA <= master_counter_q;
            RSP_OFF_SCNT:  RDATA <= slave_counter_q;
            RSP_OFF_PER:   RDATA <= period_compare_q;
            RSP_OFF_D1:    RDATA <= duty_q[0];
            RSP_OFF_D2:    RDATA <= duty_q[1];
            RSP_OFF_D3:    RDATA <= duty_q[2];
            RSP_OFF_PERB:  RDATA <= period_buffer_q;
            RSP_OFF_D1B:   RDATA <= dbuf_q[0];
            RSP_OFF_D2B:   RDATA <= dbuf_q[1];
            RSP_OFF_D3B:   RDATA <= dbuf_q[2];
            RSP_OFF_MODE:  RDATA <= {14'h0000, master_mode_q};
            RSP_OFF_OCTL:  RDATA <= {12'h0000, output_control_q};
            RSP_OFF_RUN:   RDATA <= {15'h0000, run_q};
            RSP_OFF_ISTAT: RDATA <= {12'h0000, istat_q};
            RSP_OFF_IEN:   RDATA <= {12'h0000, ien_q};
            RSP_OFF_PRE:   RDATA <= DW'(pre_q);
            default:       RDATA <= RSP_RD_ZERO;
         endcase
      end else begin
         RDATA <= RSP_RD_ZERO;
      end
   end

   // checks
   property p_clear;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      per_hit && !WR |=> master_counter_q == RSP_RST_CNT;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared on period match");

   property p_count;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      tick && !per_hit && !WR |=> master_counter_q == $past(master_counter_q) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("counter did not increment");

   property p_lock;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      !WR && $past(!WR) && master_counter_q == slave_counter_q |=> master_counter_q == slave_counter_q;
   endproperty
   a_lock: assert property (p_lock) else $error("channels lost lockstep");

   property p_tog;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      run_q && per_hit && !duty_hit[0] ##1 run_q |-> phase_q[0] != $past(phase_q[0]);
   endproperty
   a_tog: assert property (p_tog) else $error("phase one missed clear toggle");

   property p_comp;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      !SYS_RST && output_control_q[1:0] == 2'h3 |=> PHASE_TWO_POS_PIN != PHASE_TWO_NEG_PIN;
   endproperty
   a_comp: assert property (p_comp) else $error("antiphase not complement");

   property p_buf;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      per_hit && buf_on |=> duty_q[2] == $past(dbuf_q[2]) && period_compare_q == $past(period_buffer_q);
   endproperty
   a_buf: assert property (p_buf) else $error("buffer transfer missing");

   property p_irq;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      per_hit |=> istat_q[RSP_BIT_IPER];
   endproperty
   a_irq: assert property (p_irq) else $error("period flag not set");

   property p_full;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      duty_q[0] >= period_compare_q |-> !duty_hit[0];
   endproperty
   a_full: assert property (p_full) else $error("duty above period matched");

   property p_level;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      output_control_q[RSP_BIT_POS_LEVEL_SELECT] && $stable(output_control_q) |=> PHASE_THREE_POS_PIN == $past(phase_q[2]);
   endproperty
   a_level: assert property (p_level) else $error("high-active level wrong");

   property p_start;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      $past(SYS_RST) |-> master_counter_q == RSP_RST_CNT && slave_counter_q == RSP_RST_CNT;
   endproperty
   a_start: assert property (p_start) else $error("counters not zero after reset");

   property p_duty;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      run_q && duty_hit[1] ##1 run_q |-> phase_q[1] != $past(phase_q[1]);
   endproperty
   a_duty: assert property (p_duty) else $error("phase two missed duty toggle");

   property p_zero;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      tick && master_counter_q == RSP_RST_CNT && duty_q[0] == RSP_RST_CNT
         && period_compare_q != RSP_RST_CNT |-> duty_hit[0];
   endproperty
   a_zero: assert property (p_zero) else $error("zero duty gave no pulse");

   property p_irqlvl;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (istat_q & ien_q) != '0 |=> IRQ;
   endproperty
   a_irqlvl: assert property (p_irqlvl) else $error("interrupt line low with enabled flag");

   property p_cyc;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      output_control_q[RSP_BIT_TGLEN] |=> CYCLE_TOGGLE_PIN == $past(toggle_q);
   endproperty
   a_cyc: assert property (p_cyc) else $error("cycle toggle pin not following period");
endmodule : rsp_pwm3

// ==== bench/rsp_gate_model.sv ====
// rsp_gate_model: gate drive stage fed by the six pwm lines.
// assumes high-active legs; counts cycles where a leg has both switches on.
`timescale 1ns/1ps
module rsp_gate_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [2:0]  pos_on,
   input  wire logic [2:0]  neg_on,
   output logic      [15:0] shoot_q
);
   always_ff @(posedge clk) begin
      if (rst) begin
         shoot_q <= 16'h0000;
      end else if ((pos_on & neg_on) != 3'b000) begin
         shoot_q <= shoot_q + 16'h0001;
      end
   end
endmodule : rsp_gate_model

// ==== bench/tb_top.sv ====
// tb_top: self-checking bench for the three-phase pwm generator.
// assumes prescale 0, so the counter advances on every clock.
`timescale 1ns/1ps
module tb_top;
   import rsp_pkg::*;
   logic        CLK_SYS, SYS_RST, WR, RD;
   logic [4:0]  ADDR;
   logic [15:0] WDATA;
   wire  [15:0] RDATA, shoot;
   wire         IRQ, CYC, P1P, P1N, P2P, P2N, P3P, P3N;
   wire  [6:0]  pins = {CYC, P1P, P1N, P2P, P2N, P3P, P3N};
   int          errors = 0, samples_checked = 0, cyc_n = 0;
   int          edges[7], highs[7], cpl;
   logic [15:0] d;

   rsp_pwm3 u_rsp_pwm3 (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .CYCLE_TOGGLE_PIN(CYC), .PHASE_ONE_POS_PIN(P1P),
      .PHASE_ONE_NEG_PIN(P1N), .PHASE_TWO_POS_PIN(P2P), .PHASE_TWO_NEG_PIN(P2N),
      .PHASE_THREE_POS_PIN(P3P), .PHASE_THREE_NEG_PIN(P3N));
   rsp_gate_model u_rsp_gate_model (.clk(CLK_SYS), .rst(SYS_RST), .pos_on({P1P, P2P, P3P}),
      .neg_on({P1N, P2N, P3N}), .shoot_q(shoot));

   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   always @(posedge CLK_SYS) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge CLK_SYS);
      ADDR <= a; WDATA <= v; WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a);
      @(posedge CLK_SYS);
      ADDR <= a; RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd

   task automatic watch(input int n);
      logic [6:0] last;
      edges = '{default:0};
      highs = '{default:0};
      cpl = 0;
      @(posedge CLK_SYS); #1 last = pins;
      for (int i = 0; i < n; i++) begin
         @(posedge CLK_SYS); #1;
         for (int k = 0; k < 7; k++) begin
            if (pins[k] !== last[k]) edges[k]++;
            if (pins[k] === 1'b1) highs[k]++;
         end
         if ({P1P, P2P, P3P} !== ~{P1N, P2N, P3N}) cpl++;
         last = pins;
      end
   endtask : watch

   task automatic t_reset;
      rd(RSP_OFF_MCNT); check("mcnt", d, RSP_RST_CNT);
      rd(RSP_OFF_SCNT); check("scnt", d, RSP_RST_CNT);
      rd(RSP_OFF_PER);  check("per", d, RSP_RST_PER);
      rd(RSP_OFF_OCTL); check("octl", d, {12'h000, RSP_RST_OCTL});
      rd(5'h1F);        check("unmapped", d, RSP_RD_ZERO);
      $display("test reset done");
   endtask : t_reset

   task automatic t_pwm;
      wr(RSP_OFF_PER, 16'h0007); wr(RSP_OFF_D1, 16'h0002); wr(RSP_OFF_D2, 16'h0004);
      wr(RSP_OFF_D3, 16'h0009); wr(RSP_OFF_RUN, 16'h0001);
      for (int i = 0; i < 10; i++) begin
         rd(RSP_OFF_MCNT); check("cnt_bound", 16'(d <= 16'h0007), 16'h0001);
      end
      watch(16);
      check("p1_edges", 16'(edges[5]), 16'h0004);
      check("p2_edges", 16'(edges[3]), 16'h0004);
      check("p3_edges", 16'(edges[1]), 16'h0002);
      check("p1_high", 16'(highs[5] == 6 || highs[5] == 10), 16'h0001);
      check("p3_high", 16'(highs[1]), 16'h0008);
      check("n1_edges", 16'(edges[4]), 16'h0004);
      check("cpl", 16'(cpl), 16'h0000);
      check("cyc_idle", 16'(edges[6]), 16'h0000);
      $display("test pwm done");
   endtask : t_pwm

   task automatic t_toggle;
      wr(RSP_OFF_OCTL, 16'h0007);
      watch(16);
      check("cyc_tgl", 16'(edges[6]), 16'h0002);
      wr(RSP_OFF_OCTL, 16'h000B);
      watch(8);
      check("cyc_gpio", 16'(highs[6]), 16'h0008);
      wr(RSP_OFF_OCTL, 16'h0003);
      $display("test toggle done");
   endtask : t_toggle

   task automatic t_irq;
      int t0, n;
      wr(RSP_OFF_IEN, 16'h0000); wr(RSP_OFF_ICLR, 16'h000F);
      repeat (12) @(posedge CLK_SYS);
      #1 check("irq_masked", {15'h0000, IRQ}, 16'h0001 ^ 16'h0001);
      rd(RSP_OFF_ISTAT); check("stat_per", {15'h0000, d[RSP_BIT_IPER]}, 16'h0001);
      wr(RSP_OFF_IEN, 16'h0001);
      for (int r = 0; r < 2; r++) begin
         wr(RSP_OFF_ICLR, 16'h000F);
         repeat (2) @(posedge CLK_SYS);
         #1;
         n = 0;
         while (IRQ !== 1'b1 && n < 40) begin
            @(posedge CLK_SYS); #1 n++;
         end
         if (r == 1) check("irq_gap", 16'(cyc_n - t0), 16'h0008);
         t0 = cyc_n;
      end
      wr(RSP_OFF_IEN, 16'h0000); wr(RSP_OFF_ICLR, 16'h000F);
      repeat (2) @(posedge CLK_SYS);
      #1 check("irq_off", {15'h0000, IRQ}, 16'h0000);
      $display("test irq done");
   endtask : t_irq

   task automatic t_buffer;
      // software places new duty in the buffer
      wr(RSP_OFF_D1B, 16'h0000); wr(RSP_OFF_PERB, 16'h0007);
      repeat (12) @(posedge CLK_SYS);
      rd(RSP_OFF_D1); check("d1_unbuf", d, 16'h0002);
      wr(RSP_OFF_MODE, 16'h0003);
      repeat (12) @(posedge CLK_SYS);
      rd(RSP_OFF_D1);  check("d1_xfer", d, 16'h0000);
      rd(RSP_OFF_PER); check("per_xfer", d, 16'h0007);
      watch(16);
      check("p1_zero", 16'(highs[5] == 2 || highs[5] == 14), 16'h0001);
      $display("test buffer done");
   endtask : t_buffer

   task automatic t_counter;
      wr(RSP_OFF_RUN, 16'h0000); wr(RSP_OFF_MCNT, 16'h0005); wr(RSP_OFF_SCNT, 16'h0005);
      rd(RSP_OFF_MCNT); check("mcnt_wr", d, 16'h0005);
      // two clocks of run advance both counters by two
      wr(RSP_OFF_RUN, 16'h0001); wr(RSP_OFF_RUN, 16'h0000);
      rd(RSP_OFF_MCNT); check("mcnt_step", d, 16'h0007);
      rd(RSP_OFF_SCNT); check("scnt_mirror", d, 16'h0007);
      check("shoot", shoot, 16'h0000);
      $display("test counter done");
   endtask : t_counter

   initial begin
      SYS_RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 5'h00; WDATA = 16'h0000;
      repeat (8) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      t_reset();
      t_pwm();
      t_toggle();
      t_irq();
      t_buffer();
      t_counter();
      give_verdict();
   end
endmodule : tb_top
